// ===== core/irq_ctrl_consts.svh
// Offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

`define NUM_SRC 21
`define GATE_BIT 7
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define DETECT_CYCLES 1
`define CALL_CYCLES 5
`define MIN_RESPONSE (`DETECT_CYCLES + `CALL_CYCLES)
`define RETURN_CYCLES 6
`define DIVIDE_CYCLES 8
`define WORST_RESPONSE (`DETECT_CYCLES + `RETURN_CYCLES + `DIVIDE_CYCLES + `CALL_CYCLES)

`define OFF_PRIMARY_ENABLE 12'h000
`define OFF_EXT_ENABLE_A 12'h004
`define OFF_EXT_ENABLE_B 12'h008
`define OFF_PRIMARY_PRIO 12'h00c
`define OFF_EXT_PRIO_A 12'h010
`define OFF_EXT_PRIO_B 12'h014
`define OFF_PEND_SET 12'h018
`define OFF_PEND_CLR 12'h01c
`define OFF_PEND 12'h020
`define OFF_STATUS 12'h024
`define OFF_AUTOCLR 12'h028

`define RST_ENABLE 8'h00
`define RST_PRIO 8'h00
`define RST_AUTOCLR 21'h000000

`endif

// ===== core/irq_ctrl_pkg.sv
// Types shared by the interrupt controller
package irq_ctrl_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic [4:0] src;
    logic high;
  } vec_req_t;

  typedef enum logic [1:0] {
    LVL_NONE,
    LVL_LOW,
    LVL_HIGH
  } svc_level_t;
endpackage : irq_ctrl_pkg

// ===== core/irq_ctrl.sv
// Two-level priority interrupt controller with APB register access
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "irq_ctrl_consts.svh"

// Notes on behaviour
// - A source event sets its pending flag to 1.
// - Pending flags set regardless of the source enable.
// - Enabled pending source raises a vector request taken at an instruction boundary.
// - Return from service resumes the interrupted flow; the core keeps the return address.
// - A disabled pending flag produces no request.
// - Per-source enables count only while the global gate bit 7 is 1.
// - Global gate at 0 blocks all sources.
// - Enable cleared late may still let a request through after single-cycle instruction.
// - A cleared enable bit reads 0 at once, even inside a late-taken routine.
// - Selected flags clear on vector call; the rest are cleared by software.
// - Flag still set after return re-requests after one more instruction.
// - Software setting a pending flag acts like a hardware event.
// - Each source has a priority bit, low after reset.
// - High preempts low; nothing preempts high.
// - Higher priority wins; ties broken by lower source number.
// - Pending requests are sampled and decoded every clock.
// - Minimum response is 6 cycles: 1 detect plus 5 call.
// - After a return, one instruction runs before the next call.
// - Worst case 20 cycles including return and divide.
// - New request waits while equal or higher routine runs, through return plus one.
// - Service is deferred while the core stalls for a program-memory write.
// - Vectors are 0x0003 plus eight per source; lower number wins ties.
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // Source events, one pulse per condition
  input wire logic [`NUM_SRC-1:0] src_event,
  // Core sequencing
  input wire logic insn_boundary,
  input wire logic return_from_service,
  input wire logic core_stalled,
  input wire logic vec_ack,
  // Vector request to the core
  output vec_req_t vec_req,
  output svc_level_t active_level
);

  logic [7:0] primary_enable_reg;
  logic [7:0] extended_enable_reg_a;
  logic [7:0] extended_enable_reg_b;
  logic [7:0] primary_priority_reg;
  logic [7:0] extended_priority_reg_a;
  logic [7:0] extended_priority_reg_b;
  logic [`NUM_SRC-1:0] pending;
  logic [`NUM_SRC-1:0] autoclr;
  logic [`NUM_SRC-1:0] pend_sampled;
  logic low_active;
  logic high_active;
  logic hold_one;
  logic [31:0] rdata;
  logic ready;

  // Register decode
  wire logic [11:0] addr = apb_req.paddr;
  wire logic access = apb_req.psel && apb_req.penable && !ready;
  // Writes land at the edge that completes the transfer, while the request still stands
  wire logic wr = apb_req.psel && apb_req.penable && ready && apb_req.pwrite;
  wire logic wr_pen = wr && addr == `OFF_PRIMARY_ENABLE;
  wire logic wr_ena = wr && addr == `OFF_EXT_ENABLE_A;
  wire logic wr_enb = wr && addr == `OFF_EXT_ENABLE_B;
  wire logic wr_ppr = wr && addr == `OFF_PRIMARY_PRIO;
  wire logic wr_pra = wr && addr == `OFF_EXT_PRIO_A;
  wire logic wr_prb = wr && addr == `OFF_EXT_PRIO_B;
  wire logic wr_set = wr && addr == `OFF_PEND_SET;
  wire logic wr_clr = wr && addr == `OFF_PEND_CLR;
  wire logic wr_acl = wr && addr == `OFF_AUTOCLR;
  wire logic mapped = addr == `OFF_PRIMARY_ENABLE || addr == `OFF_EXT_ENABLE_A ||
                      addr == `OFF_EXT_ENABLE_B || addr == `OFF_PRIMARY_PRIO ||
                      addr == `OFF_EXT_PRIO_A || addr == `OFF_EXT_PRIO_B ||
                      addr == `OFF_PEND_SET || addr == `OFF_PEND_CLR ||
                      addr == `OFF_PEND || addr == `OFF_STATUS ||
                      addr == `OFF_AUTOCLR;
  wire logic [31:0] wdata = apb_req.pwdata;

  // Source enable and priority vectors in source order
  wire logic [23:0] en_all = {extended_enable_reg_b, extended_enable_reg_a,
                              primary_enable_reg[6:0], 1'b0};
  wire logic [23:0] pr_all = {extended_priority_reg_b, extended_priority_reg_a,
                              primary_priority_reg[6:0], 1'b0};
  wire logic [`NUM_SRC-1:0] src_en = en_all[`NUM_SRC:1];
  wire logic [`NUM_SRC-1:0] src_high = pr_all[`NUM_SRC:1];
  wire logic gate = primary_enable_reg[`GATE_BIT];

  // Masking and level split; enables are the live register so a clear acts at once
  wire logic [`NUM_SRC-1:0] armed = pend_sampled & src_en & {`NUM_SRC{gate}};
  wire logic [`NUM_SRC-1:0] armed_hi = armed & src_high;
  wire logic [`NUM_SRC-1:0] armed_lo = armed & ~src_high;

  // Lowest-index winner per level, one generate chain
  logic [`NUM_SRC:0] hi_seen;
  logic [`NUM_SRC:0] lo_seen;
  logic [`NUM_SRC-1:0] hi_win;
  logic [`NUM_SRC-1:0] lo_win;
  assign hi_seen[0] = 1'b0;
  assign lo_seen[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_arb
      assign hi_win[g] = armed_hi[g] && !hi_seen[g];
      assign lo_win[g] = armed_lo[g] && !lo_seen[g];
      assign hi_seen[g+1] = hi_seen[g] || armed_hi[g];
      assign lo_seen[g+1] = lo_seen[g] || armed_lo[g];
    end
  endgenerate

  function automatic logic [4:0] onehot_idx(input logic [`NUM_SRC-1:0] oh);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (oh[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : onehot_idx

  // Preemption: high allowed unless high running; low only when idle
  wire logic hi_ok = |armed_hi && !high_active;
  wire logic lo_ok = |armed_lo && !high_active && !low_active;
  wire logic take = (hi_ok || lo_ok) && insn_boundary && !core_stalled &&
                    !hold_one && !vec_req.valid;
  wire logic [4:0] win_src = hi_ok ? onehot_idx(hi_win) : onehot_idx(lo_win);
  wire logic [15:0] win_vec = `VEC_BASE + {8'h00, win_src, 3'h0};
  wire logic [`NUM_SRC-1:0] ack_clr = (vec_ack && vec_req.valid) ?
      (autoclr & (`NUM_SRC'(1) << vec_req.src)) : '0;
  wire logic [`NUM_SRC-1:0] sw_set = wr_set ? wdata[`NUM_SRC-1:0] : '0;
  wire logic [`NUM_SRC-1:0] sw_clr = wr_clr ? wdata[`NUM_SRC-1:0] : '0;
  // Set beats any clear arriving in the same cycle
  wire logic [`NUM_SRC-1:0] next_pending =
      ((pending & ~sw_clr & ~ack_clr) | src_event | sw_set);

  always_comb begin
    case (addr)
      `OFF_PRIMARY_ENABLE: rdata = {24'h000000, primary_enable_reg};
      `OFF_EXT_ENABLE_A: rdata = {24'h000000, extended_enable_reg_a};
      `OFF_EXT_ENABLE_B: rdata = {24'h000000, extended_enable_reg_b};
      `OFF_PRIMARY_PRIO: rdata = {24'h000000, primary_priority_reg};
      `OFF_EXT_PRIO_A: rdata = {24'h000000, extended_priority_reg_a};
      `OFF_EXT_PRIO_B: rdata = {24'h000000, extended_priority_reg_b};
      `OFF_PEND: rdata = {11'h000, pending};
      `OFF_STATUS: rdata = {26'h0000000, high_active, low_active, hold_one,
                            vec_req.valid, vec_req.high, gate};
      `OFF_AUTOCLR: rdata = {11'h000, autoclr};
      default: rdata = 32'h00000000;
    endcase
  end

  // APB: one wait state, error on unmapped address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready <= 1'b0;
      apb_rsp <= '0;
    end else begin
      ready <= access;
      apb_rsp.pready <= access;
      apb_rsp.pslverr <= access && !mapped;
      apb_rsp.prdata <= (access && !apb_req.pwrite) ? rdata : 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      primary_enable_reg <= `RST_ENABLE;
      extended_enable_reg_a <= `RST_ENABLE;
      extended_enable_reg_b <= `RST_ENABLE;
      primary_priority_reg <= `RST_PRIO;
      extended_priority_reg_a <= `RST_PRIO;
      extended_priority_reg_b <= `RST_PRIO;
      autoclr <= `RST_AUTOCLR;
    end else begin
      if (wr_pen) primary_enable_reg <= wdata[7:0];
      if (wr_ena) extended_enable_reg_a <= wdata[7:0];
      if (wr_enb) extended_enable_reg_b <= wdata[7:0];
      if (wr_ppr) primary_priority_reg <= wdata[7:0];
      if (wr_pra) extended_priority_reg_a <= wdata[7:0];
      if (wr_prb) extended_priority_reg_b <= wdata[7:0];
      if (wr_acl) autoclr <= wdata[`NUM_SRC-1:0];
    end
  end

  // Pending flags and one-cycle detection stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending <= '0;
      pend_sampled <= '0;
    end else begin
      pending <= next_pending;
      pend_sampled <= pending & ~ack_clr;
    end
  end

  // Request strobe held until the core acknowledges the call
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_req <= '0;
    end else if (take) begin
      vec_req.valid <= 1'b1;
      vec_req.vector <= win_vec;
      vec_req.src <= win_src;
      vec_req.high <= hi_ok;
    end else if (vec_ack) begin
      vec_req.valid <= 1'b0;
    end
  end

  // Service nesting; the core keeps return addresses, we track levels only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_active <= 1'b0;
      high_active <= 1'b0;
      hold_one <= 1'b0;
      active_level <= LVL_NONE;
    end else begin
      if (vec_ack && vec_req.valid) begin
        if (vec_req.high) high_active <= 1'b1;
        else low_active <= 1'b1;
        active_level <= vec_req.high ? LVL_HIGH : LVL_LOW;
      end else if (return_from_service) begin
        if (high_active) begin
          high_active <= 1'b0;
          active_level <= low_active ? LVL_LOW : LVL_NONE;
        end else begin
          low_active <= 1'b0;
          active_level <= LVL_NONE;
        end
      end
      // One instruction must complete after a return before the next call
      if (return_from_service) hold_one <= 1'b1;
      else if (insn_boundary) hold_one <= 1'b0;
    end
  end

  // Cycles a serviceable request has waited for its call; a stall restarts the count
  logic [4:0] resp_wait;
  wire logic resp_waiting = (hi_ok || lo_ok) && !vec_req.valid && !core_stalled;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_wait <= 5'h00;
    end else if (!resp_waiting) begin
      resp_wait <= 5'h00;
    end else if (resp_wait != 5'h1f) begin
      resp_wait <= resp_wait + 5'h01;
    end
  end

  // Late clear of an enable: requests already raised stand; the enable reads 0

  chk_hold_after_return: assert property (@(posedge sys_clk) disable iff (rst)
    return_from_service |=> !take)
    else $error("call raised directly after return");

  chk_gate_blocks: assert property (@(posedge sys_clk) disable iff (rst)
    !gate |-> !take)
    else $error("request taken with gate closed");

  chk_disabled_src: assert property (@(posedge sys_clk) disable iff (rst)
    take |-> src_en[win_src])
    else $error("disabled source won arbitration");

  chk_high_no_preempt: assert property (@(posedge sys_clk) disable iff (rst)
    high_active |-> !take)
    else $error("high routine preempted");

  chk_pend_sets: assert property (@(posedge sys_clk) disable iff (rst)
    src_event[0] |=> pending[0])
    else $error("event lost");

  chk_vector_map: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(vec_req.valid) |-> vec_req.vector == 16'h0003 + {8'h00, vec_req.src, 3'h0})
    else $error("vector address wrong");

  chk_detect_delay: assert property (@(posedge sys_clk) disable iff (rst)
    take |-> |($past(pending, 1) & (`NUM_SRC'(1) << win_src)))
    else $error("request taken without one detect cycle");

  chk_stall_defer: assert property (@(posedge sys_clk) disable iff (rst)
    core_stalled |=> !$rose(vec_req.valid))
    else $error("request raised during stall");

  chk_high_first: assert property (@(posedge sys_clk) disable iff (rst)
    take && |armed_hi |-> src_high[win_src])
    else $error("low beat high");

  chk_strobe_holds: assert property (@(posedge sys_clk) disable iff (rst)
    vec_req.valid && !vec_ack |=> vec_req.valid && $stable(vec_req.vector))
    else $error("vector request dropped before ack");

  chk_worst_response: assert property (@(posedge sys_clk) disable iff (rst)
    resp_wait < 5'(`WORST_RESPONSE))
    else $error("request waited past the worst-case response");

  chk_low_blocks_low: assert property (@(posedge sys_clk) disable iff (rst)
    take && low_active |-> hi_ok)
    else $error("low request taken while low routine runs");

  chk_level_tracks: assert property (@(posedge sys_clk) disable iff (rst)
    active_level == (high_active ? LVL_HIGH : low_active ? LVL_LOW : LVL_NONE))
    else $error("active level out of step with nesting");

  chk_ack_clears: assert property (@(posedge sys_clk) disable iff (rst)
    vec_ack && vec_req.valid |=> !(|(pending & $past(ack_clr & ~src_event & ~sw_set))))
    else $error("hardware-cleared flag still set after call");

  chk_autoclr_only: assert property (@(posedge sys_clk) disable iff (rst)
    vec_ack && vec_req.valid && pending[vec_req.src] && !autoclr[vec_req.src] &&
    !sw_clr[vec_req.src] |=> |(pending & $past(`NUM_SRC'(1) << vec_req.src)))
    else $error("software-cleared flag lost on call");

  chk_valid_drops: assert property (@(posedge sys_clk) disable iff (rst)
    vec_ack && vec_req.valid |=> !vec_req.valid)
    else $error("request still standing after ack");

  chk_sw_set: assert property (@(posedge sys_clk) disable iff (rst)
    wr_set |=> (pending & $past(sw_set)) == $past(sw_set))
    else $error("software set did not reach pending");

  chk_sw_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_clr |=> !(|(pending & $past(sw_clr & ~src_event & ~sw_set))))
    else $error("software clear did not remove flag");

  chk_event_any: assert property (@(posedge sys_clk) disable iff (rst)
    |src_event |=> (pending & $past(src_event)) == $past(src_event))
    else $error("source event did not set its flag");

  chk_no_stalled_take: assert property (@(posedge sys_clk) disable iff (rst)
    core_stalled |-> !take)
    else $error("call started during stall");

  chk_boundary_only: assert property (@(posedge sys_clk) disable iff (rst)
    !insn_boundary |-> !take)
    else $error("call started inside an instruction");

  chk_prio_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> src_high == '0)
    else $error("priority not low after reset");

  chk_sampled_every: assert property (@(posedge sys_clk) disable iff (rst)
    pend_sampled == ($past(pending) & ~$past(ack_clr)))
    else $error("detect stage skipped a cycle");

  chk_hold_clears: assert property (@(posedge sys_clk) disable iff (rst)
    hold_one && insn_boundary && !return_from_service |=> !hold_one)
    else $error("post-return hold outlived one instruction");

  chk_enable_reads: assert property (@(posedge sys_clk) disable iff (rst)
    wr_pen |=> primary_enable_reg == $past(wdata[7:0]))
    else $error("enable write not visible at once");

  chk_late_request: assert property (@(posedge sys_clk) disable iff (rst)
    vec_req.valid && !vec_ack && !gate |=> vec_req.valid)
    else $error("raised request withdrawn by late clear");

  chk_gate_bit: assert property (@(posedge sys_clk) disable iff (rst)
    take |-> gate && src_en[win_src])
    else $error("source enable used with gate closed");

  chk_return_level: assert property (@(posedge sys_clk) disable iff (rst)
    return_from_service && high_active && !vec_ack |=> !high_active)
    else $error("return did not end high routine");

  chk_vector_src: assert property (@(posedge sys_clk) disable iff (rst)
    vec_req.valid |-> vec_req.src < `NUM_SRC)
    else $error("request names a missing source");

  chk_high_preempts: assert property (@(posedge sys_clk) disable iff (rst)
    hi_ok && insn_boundary && !core_stalled && !hold_one && !vec_req.valid |-> take)
    else $error("high request not taken over low routine");

endmodule : irq_ctrl

// ===== tb/core_model.sv
// Behavioural model of the core that sequences instructions and service routines
module core_model
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Controls from the bench
  input wire logic [3:0] ack_wait,
  input wire logic stall_req,
  input wire logic ret_req,
  // Controller side
  input wire vec_req_t vec_req,
  output logic insn_boundary,
  output logic return_from_service,
  output logic core_stalled,
  output logic vec_ack
);
  logic [3:0] wait_cnt;
  logic acked;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      insn_boundary <= 1'b0;
      return_from_service <= 1'b0;
      core_stalled <= 1'b0;
      vec_ack <= 1'b0;
      wait_cnt <= 4'h0;
      acked <= 1'b0;
    end else begin
      // Single-cycle instructions, so every cycle is a boundary unless stalled
      core_stalled <= stall_req;
      insn_boundary <= !stall_req;
      return_from_service <= ret_req;
      vec_ack <= 1'b0;
      if (!vec_req.valid) begin
        acked <= 1'b0;
      end
      // A slow core lets the request stand for a few cycles before accepting
      if (vec_req.valid && !acked) begin
        if (wait_cnt == ack_wait) begin
          vec_ack <= 1'b1;
          acked <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule : core_model

// ===== tb/irq_ctrl_bench.sv
// Self-checking bench for the interrupt controller
`include "irq_ctrl_consts.svh"
module irq_ctrl_bench
  import irq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, insn_boundary, return_from_service, core_stalled, vec_ack;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic [`NUM_SRC-1:0] src_event;
  vec_req_t vec_req;
  svc_level_t active_level;
  logic [3:0] ack_wait;
  logic stall_req, ret_req;
  int fails, checked, lat;
  logic [31:0] rdat;
  logic err;

  irq_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .src_event(src_event), .insn_boundary(insn_boundary),
    .return_from_service(return_from_service), .core_stalled(core_stalled),
    .vec_ack(vec_ack), .vec_req(vec_req), .active_level(active_level));
  core_model u_core (.sys_clk(sys_clk), .rst(rst), .ack_wait(ack_wait),
    .stall_req(stall_req), .ret_req(ret_req), .vec_req(vec_req),
    .insn_boundary(insn_boundary), .return_from_service(return_from_service),
    .core_stalled(core_stalled), .vec_ack(vec_ack));

  always #4 sys_clk = ~sys_clk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Setup cycle, then access held until pready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n == 20) fails++;
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 32'h0, r, e);
    check(nm, r, exp);
  endtask : rd

  task automatic ev(input int s);
    @(posedge sys_clk);
    src_event[s] <= 1'b1;
    @(posedge sys_clk);
    src_event <= '0;
  endtask : ev

  task automatic ret();
    @(posedge sys_clk);
    ret_req <= 1'b1;
    @(posedge sys_clk);
    ret_req <= 1'b0;
  endtask : ret

  task automatic quiet(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      if (vec_req.valid !== 1'b0) hit = 1'b1;
    end
    check("quiet", hit, 1'b0);
  endtask : quiet

  // Waits for the request, checks it, then waits eight cycles, too few for the core to accept when ack_wait is 4'hf
  task automatic call(input logic [15:0] v, input logic hi, output int n);
    n = 0;
    while (vec_req.valid !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check("vector", vec_req.vector, v);
    check("high", vec_req.high, hi);
    repeat (8) @(posedge sys_clk);
  endtask : call

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    apb_req = '0;
    src_event = '0;
    ack_wait = 4'h0;
    stall_req = 1'b0;
    ret_req = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`OFF_PRIMARY_ENABLE, 32'h0, "enable");
    rd(`OFF_PRIMARY_PRIO, 32'h0, "prio");
    xfer(12'h100, 1'b0, 32'h0, rdat, err);
    check("unmapped data", rdat, 32'h0);
    check("unmapped err", err, 1'b1);
    ev(1);
    quiet(8);
    rd(`OFF_PEND, 32'h2, "pending");
    wr(`OFF_PRIMARY_ENABLE, 32'h80);
    quiet(8);
    wr(`OFF_PRIMARY_ENABLE, 32'h02);
    quiet(8);
    wr(`OFF_PRIMARY_ENABLE, 32'h82);
    call(16'h000b, 1'b0, lat);
    check("level", active_level, LVL_LOW);
    rd(`OFF_PEND, 32'h2, "kept");
    ret();
    call(16'h000b, 1'b0, lat);
    wr(`OFF_PEND_CLR, 32'h2);
    ret();
    quiet(8);
    wr(`OFF_PRIMARY_ENABLE, 32'h81);
    ev(0);
    call(16'h0003, 1'b0, lat);
    check("latency", lat <= 6, 1'b1);
    wr(`OFF_PEND_CLR, 32'h1);
    ret();
    ack_wait <= 4'h3;
    wr(`OFF_PRIMARY_PRIO, 32'h60);
    wr(`OFF_PRIMARY_ENABLE, 32'hf4);
    wr(`OFF_PEND_SET, 32'h14);
    call(16'h0013, 1'b0, lat);
    wr(`OFF_PEND_SET, 32'h20);
    call(16'h002b, 1'b1, lat);
    check("level", active_level, LVL_HIGH);
    wr(`OFF_PEND_SET, 32'h40);
    quiet(8);
    wr(`OFF_PEND_CLR, 32'h24);
    ret();
    call(16'h0033, 1'b1, lat);
    wr(`OFF_PEND_CLR, 32'h1fffff);
    ret();
    ret();
    ack_wait <= 4'h0;
    wr(`OFF_AUTOCLR, 32'h1);
    wr(`OFF_PRIMARY_ENABLE, 32'h81);
    stall_req <= 1'b1;
    ev(0);
    quiet(8);
    stall_req <= 1'b0;
    call(16'h0003, 1'b0, lat);
    rd(`OFF_PEND, 32'h0, "autoclear");
    ret();
    ack_wait <= 4'hf;
    wr(`OFF_PEND_SET, 32'h1);
    call(16'h0003, 1'b0, lat);
    wr(`OFF_PRIMARY_ENABLE, 32'h0);
    wr(`OFF_PRIMARY_ENABLE, 32'h0);
    rd(`OFF_PRIMARY_ENABLE, 32'h0, "cleared enable");
    check("late level", active_level, LVL_LOW);
    print_verdict();
  end
endmodule : irq_ctrl_bench
